// >>> mrpc_defines.svh
`ifndef MRPC_DEFINES_SVH
`define MRPC_DEFINES_SVH

// System clock period and the divided reference clock period, in ns.
`define MRPC_SYS_PERIOD_NS 5
`define MRPC_REFO_PERIOD_NS 20
// Half period of the divided reference output, in system clock cycles.
`define MRPC_REFO_HALF_CYC ((`MRPC_REFO_PERIOD_NS / `MRPC_SYS_PERIOD_NS) / 2)
// Reference periods per slow (10 Mbps) RMII dibit slot and per slow MII half clock.
`define MRPC_SLOW_DIV 10
// Configuration reset value: MII, PHY supplies clock, 100 Mbps.
`define MRPC_CFG_RST 3'h1

`endif

// >>> mrpc_pkg.sv
package mrpc_pkg;

  typedef enum logic [0:0] {
    MRPC_IDLE = 1'b0,
    MRPC_SEND = 1'b1
  } mrpc_state_type;

  typedef struct packed {
    logic rmii;
    logic dce;
    logic fast;
  } mrpc_cfg_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [3:0] data;
  } mrpc_tx_req_type;

endpackage

// >>> mrpc_port.sv
`timescale 1ns/1ps
`include "mrpc_defines.svh"
module mrpc_port #(
  parameter int REFO_HALF = `MRPC_REFO_HALF_CYC,
  parameter int SLOW_DIV = `MRPC_SLOW_DIV
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Configuration.
  input wire mrpc_pkg::mrpc_cfg_type cfg_in,
  // Clock pins.
  input wire logic ref_clk_in,
  output logic divided_reference_clock_output_q,
  input wire logic tx_clk_in,
  output logic tx_clk_out_q,
  output logic tx_clk_oe_q,
  input wire logic rx_clk_in,
  output logic rx_clk_out_q,
  output logic rx_clk_oe_q,
  // Transmit stream from the MAC.
  input wire mrpc_pkg::mrpc_tx_req_type tx_req,
  output logic tx_ready_q,
  // Transmit pins.
  output logic tx_en_q,
  output logic [3:0] txd_q,
  // Receive pins and sampled data.
  input wire logic [3:0] rxd_in,
  output logic rx_strobe_q,
  output logic [3:0] rx_data_q
);

  // The counters are 8 and 4 bits wide; other values cannot be served.
  if (REFO_HALF < 1 || REFO_HALF > 255) begin : g_bad_refo_half
    $error("REFO_HALF out of range");
  end
  if (SLOW_DIV < 2 || SLOW_DIV > 15) begin : g_bad_slow_div
    $error("SLOW_DIV out of range");
  end

  mrpc_pkg::mrpc_cfg_type cfg_q;
  mrpc_pkg::mrpc_state_type state_q;
  logic [7:0] refo_cnt_q;
  logic ref_q, ref_prev_q, txc_q, txc_prev_q, rxc_q, rxc_prev_q;
  logic [3:0] slow_cnt_q;
  logic gen_clk_q;
  logic ref_rise, slow_hit, gen_toggle, gen_rise, tx_tick, rx_tick;

  // Divided reference output from the system clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refo_cnt_q <= 8'h00;
      divided_reference_clock_output_q <= 1'b0;
    end else if (refo_cnt_q == 8'(REFO_HALF - 1)) begin
      refo_cnt_q <= 8'h00;
      divided_reference_clock_output_q <= ~divided_reference_clock_output_q;
    end else begin
      refo_cnt_q <= refo_cnt_q + 8'h01;
    end
  end

  // Pin clocks are synchronous inputs; their rising edges become ticks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_q <= 1'b0;
      ref_prev_q <= 1'b0;
      txc_q <= 1'b0;
      txc_prev_q <= 1'b0;
      rxc_q <= 1'b0;
      rxc_prev_q <= 1'b0;
    end else begin
      ref_q <= ref_clk_in;
      ref_prev_q <= ref_q;
      txc_q <= tx_clk_in;
      txc_prev_q <= txc_q;
      rxc_q <= rx_clk_in;
      rxc_prev_q <= rxc_q;
    end
  end

  always_comb begin
    // The reference input only matters in RMII or when the device makes the clock.
    ref_rise = ref_q && !ref_prev_q && (cfg_q.rmii || cfg_q.dce);
    slow_hit = ref_rise && (slow_cnt_q == 4'(SLOW_DIV - 1));
    gen_toggle = !cfg_q.rmii && cfg_q.dce && (cfg_q.fast ? ref_rise : slow_hit);
    gen_rise = gen_toggle && !gen_clk_q;
    if (cfg_q.rmii) begin
      tx_tick = cfg_q.fast ? ref_rise : slow_hit;
      rx_tick = cfg_q.fast ? ref_rise : slow_hit;
    end else if (cfg_q.dce) begin
      tx_tick = gen_rise;
      rx_tick = gen_rise;
    end else begin
      tx_tick = txc_q && !txc_prev_q;
      rx_tick = rxc_q && !rxc_prev_q;
    end
  end

  // Slow slot counter and the generated MII clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_cnt_q <= 4'h0;
    end else if (slow_hit) begin
      slow_cnt_q <= 4'h0;
    end else if (ref_rise) begin
      slow_cnt_q <= slow_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_clk_q <= 1'b0;
    end else if (cfg_q.rmii || !cfg_q.dce) begin
      gen_clk_q <= 1'b0;
    end else if (gen_toggle) begin
      gen_clk_q <= ~gen_clk_q;
    end
  end

  // Clock pin drive; outputs are enabled only while the device supplies the clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_clk_out_q <= 1'b0;
      rx_clk_out_q <= 1'b0;
      tx_clk_oe_q <= 1'b0;
      rx_clk_oe_q <= 1'b0;
    end else begin
      tx_clk_out_q <= gen_toggle ? ~gen_clk_q : gen_clk_q;
      rx_clk_out_q <= gen_toggle ? ~gen_clk_q : gen_clk_q;
      tx_clk_oe_q <= !cfg_q.rmii && cfg_q.dce;
      rx_clk_oe_q <= !cfg_q.rmii && cfg_q.dce;
    end
  end

  // Configuration is taken only while no frame is in progress.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `MRPC_CFG_RST;
    end else if (state_q == mrpc_pkg::MRPC_IDLE && !tx_en_q) begin
      cfg_q <= cfg_in;
    end
  end

  // Transmit sequencing: one nibble or dibit per tick, enable low for a tick after a frame.
  logic last_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= mrpc_pkg::MRPC_IDLE;
      tx_en_q <= 1'b0;
      txd_q <= 4'h0;
      tx_ready_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      tx_ready_q <= 1'b0;
      if (tx_tick) begin
        case (state_q)
          mrpc_pkg::MRPC_IDLE: begin
            if (tx_req.valid) begin
              state_q <= mrpc_pkg::MRPC_SEND;
              tx_en_q <= 1'b1;
              tx_ready_q <= 1'b1;
              last_q <= tx_req.last;
              txd_q <= cfg_q.rmii ? {2'h0, tx_req.data[1:0]} : tx_req.data;
            end
          end
          mrpc_pkg::MRPC_SEND: begin
            if (last_q || !tx_req.valid) begin
              state_q <= mrpc_pkg::MRPC_IDLE;
              tx_en_q <= 1'b0;
              txd_q <= 4'h0;
            end else begin
              tx_en_q <= 1'b1;
              tx_ready_q <= 1'b1;
              last_q <= tx_req.last;
              txd_q <= cfg_q.rmii ? {2'h0, tx_req.data[1:0]} : tx_req.data;
            end
          end
          default: begin
            state_q <= mrpc_pkg::MRPC_IDLE;
            tx_en_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Receive sampling strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_strobe_q <= 1'b0;
      rx_data_q <= 4'h0;
    end else begin
      rx_strobe_q <= rx_tick;
      if (rx_tick) begin
        rx_data_q <= cfg_q.rmii ? {2'h0, rxd_in[1:0]} : rxd_in;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_refo_period: assert property ($rose(divided_reference_clock_output_q) |=>
    !$rose(divided_reference_clock_output_q) [*3] ##1 $rose(divided_reference_clock_output_q))
    else $error("divided reference period wrong");
  a_txen_on_tick: assert property ($changed(tx_en_q) |-> $past(tx_tick))
    else $error("transmit enable moved off a clock edge");
  a_txd_hold: assert property (!$past(tx_tick) |-> $stable(txd_q))
    else $error("transmit data moved off a clock edge");
  a_frame_gap: assert property ($fell(tx_en_q) |=> !$rose(tx_en_q) [*3])
    else $error("no idle gap after frame");
  a_first_nibble: assert property ($rose(tx_en_q) |-> tx_ready_q && $past(tx_req.valid))
    else $error("enable not with first nibble");
  a_rmii_dibit: assert property (cfg_q.rmii && tx_en_q |-> txd_q[3:2] == 2'h0)
    else $error("upper lines active in RMII");
  a_gen_fast: assert property (!cfg_q.rmii && cfg_q.dce && cfg_q.fast && ref_rise
    |=> tx_clk_out_q != $past(tx_clk_out_q) && tx_clk_oe_q)
    else $error("generated clock did not follow reference");
  a_slow_sample: assert property (rx_strobe_q && cfg_q.rmii && !cfg_q.fast
    |=> !rx_strobe_q [*8])
    else $error("slow receive sampled too often");

  c_frame_sent: cover property ($rose(tx_en_q) ##[1:200] $fell(tx_en_q));
  c_rmii_slow: cover property (cfg_q.rmii && !cfg_q.fast && rx_strobe_q);
  c_dce_clock: cover property (tx_clk_oe_q && $rose(tx_clk_out_q));

endmodule // mrpc_port

// >>> mrpc_phy_model.sv
`timescale 1ns/1ps
module mrpc_phy_model (
  // Mode of the port.
  input wire mrpc_pkg::mrpc_cfg_type cfg,
  // Clocks and receive data toward the device.
  output logic ref_clk,
  output logic phy_clk,
  output logic [3:0] rxd
);
  // Data is set before the clocks so that their first edge shifts a known value.
  initial begin
    rxd = 4'h5;
    ref_clk = 1'b0;
    phy_clk = 1'b0;
  end
  // The reference runs only where it is used and is tied low otherwise.
  always #10 ref_clk = (cfg.rmii || cfg.dce) ? !ref_clk : 1'b0;
  // The PHY makes the MII clocks only while it owns them.
  always #(cfg.fast ? 20 : 200) phy_clk = (!cfg.rmii && !cfg.dce) ? !phy_clk : 1'b0;
  // Data moves on falling edges, clear of the sampling edge.
  always @(negedge ref_clk or negedge phy_clk) rxd <= {rxd[2:0], rxd[3] ^ rxd[2]};
endmodule // mrpc_phy_model

// >>> mii_rmii_port_clocking_tx_enable_test.sv
`timescale 1ns/1ps
module mii_rmii_port_clocking_tx_enable_test;
  logic clk;
  logic rst;
  mrpc_pkg::mrpc_cfg_type cfg;
  mrpc_pkg::mrpc_tx_req_type tx_req;
  logic ref_clk, phy_clk, div_o, tx_co, tx_oe, rx_co, rx_oe, ready, tx_en, rx_stb;
  logic [3:0] txd, rxd, rx_data, prev_rxd;
  logic [5:0] mon;
  logic [3:0] exp_q[$];
  logic [2:0] modes [6] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h4};
  logic [31:0] seed = 32'hDDCD;
  int error_cnt = 0;
  int check_count = 0;
  int p;
  assign mon = {ready, tx_en, rx_co, rx_stb, tx_co, div_o};

  mrpc_port mrpc_port_i (.clk(clk), .rst(rst), .cfg_in(cfg), .ref_clk_in(ref_clk),
    .divided_reference_clock_output_q(div_o), .tx_clk_in(phy_clk), .tx_clk_out_q(tx_co),
    .tx_clk_oe_q(tx_oe), .rx_clk_in(phy_clk), .rx_clk_out_q(rx_co), .rx_clk_oe_q(rx_oe),
    .tx_req(tx_req), .tx_ready_q(ready), .tx_en_q(tx_en), .txd_q(txd), .rxd_in(rxd),
    .rx_strobe_q(rx_stb), .rx_data_q(rx_data));
  mrpc_phy_model mrpc_phy_model_i (.cfg(cfg), .ref_clk(ref_clk), .phy_clk(phy_clk), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  function automatic logic [3:0] nib();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[3:0];
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_lvl(input int w, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mon[w] !== v && n < 1000);
    if (mon[w] !== v) begin
      chk("wait", 8'h00, 8'h01);
      finish_test();
    end
  endtask

  // Full period of a monitored signal, rise to rise, in system cycles.
  task automatic per(input int w, input int e);
    int a, b;
    wait_lvl(w, 1'b0, a);
    wait_lvl(w, 1'b1, a);
    wait_lvl(w, 1'b0, a);
    wait_lvl(w, 1'b1, b);
    chk("period", 8'(e), 8'(a + b));
  endtask

  // A frame without the end marker ends by underrun.
  task automatic send(input int len, input logic lst);
    logic [3:0] d;
    int n;
    for (int i = 0; i < len; i++) begin
      d = nib();
      exp_q.push_back(cfg.rmii ? {2'b00, d[1:0]} : d);
      tx_req <= '{valid: 1'b1, last: lst && i == len - 1, data: d};
      wait_lvl(5, 1'b1, n);
    end
    tx_req <= '0;
    wait_lvl(4, 1'b0, n);
    chk("txd_idle", 8'h00, {4'h0, txd});
  endtask

  always @(posedge clk) begin
    prev_rxd <= rxd;
    if (rx_stb === 1'b1) begin
      chk("rx_data", {4'h0, cfg.rmii ? {2'b00, prev_rxd[1:0]} : prev_rxd}, {4'h0, rx_data});
    end
    if (ready === 1'b1 && exp_q.size() > 0) begin
      chk("txd", {4'h0, exp_q.pop_front()}, {4'h0, txd});
      chk("tx_en", 8'h01, {7'h00, tx_en});
    end else if (ready === 1'b1) begin
      chk("tx_ready", 8'h00, 8'h01);
    end
  end

  initial begin
    rst = 1'b1;
    cfg = '0;
    tx_req = '0;
    prev_rxd = '0;
    foreach (modes[m]) begin
      @(posedge clk);
      rst <= 1'b1;
      cfg <= modes[m];
      repeat (m == 0 ? 4 : 20) @(posedge clk);
      rst <= 1'b0;
      // Configuration lands one edge after release and the enables one edge later.
      repeat (3) @(posedge clk);
      p = (cfg.rmii ? 4 : 8) * (cfg.fast ? 1 : 10);
      chk("clk_oe", {6'h00, {2{!cfg.rmii && cfg.dce}}}, {6'h00, tx_oe, rx_oe});
      per(0, 4);
      per(2, p);
      if (!cfg.rmii && cfg.dce) begin
        per(1, p);
        per(3, p);
      end
      send(5, 1'b1);
      send(3, 1'b0);
      $display("mode %0h done", modes[m]);
    end
    finish_test();
  end
endmodule // mii_rmii_port_clocking_tx_enable_test
